/* core/bcs_decoder.sv */
`timescale 1ns/1ps
// Overview of operation
// [R1] EISA cycles decode from LA and byte enables
// [R2] ISA cycles decode from LA, SA, SHBE; the address is formed from LA and SA only, SHBE is not used
// [R3] Classify cycle into five address spaces
// [R4] Assert BIOS chip select for BIOS space
// [R5] Four 16K low regions, one 64K high
// [R6] Conventional regions need their own enable bit
// [R7] Alias at 16M, 4G-1M and 4G
// [R8] Aliases also need second register enable
// [R9] Decode low and high VGA BIOS regions
// [R10] VGA enables alias to low regions 1, 2
// [R11] Enlarged BIOS window FFF80000h to FFFDFFFFh
// [R12] Enlarged BIOS needs bit 5 enable
// [R13] Latch location strap at end of reset
// [R14] Strap steers X-Bus transceivers on BIOS access
// [R15] Alias range bases and combined enables
// [R16] Deassert for I/O, unmapped, disabled regions
module bcs_decoder
   import bcs_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Bus cycle from the current master.
   input wire bcs_cycle_t cycle,
   // Hits from the other decoders of the device.
   input wire bcs_other_hit_t other_hit,
   // Configuration bits.
   input wire logic [7:0] bios_cs_a,
   input wire logic [7:0] bios_cs_b,
   // Strap pin.
   input wire logic bios_location_strap_n,
   // Outputs.
   output logic bios_chip_select_n,
   output bcs_space_t space,
   output logic [31:0] byte_addr,
   output logic bios_on_xbus,
   output logic xbus_xcvr_en_n,
   output logic xbus_xcvr_dir
);

   // ==========================================================
   // Address forming.
   logic [1:0] low_bits;
   logic [31:0] addr;

   always_comb begin
      if (cycle.eisa_master) begin
         // Lowest active byte enable gives the low address bits.
         casez (cycle.be_n) // [R1]
            4'b???0: low_bits = 2'h0;
            4'b??01: low_bits = 2'h1;
            4'b?011: low_bits = 2'h2;
            4'b0111: low_bits = 2'h3;
            default: low_bits = 2'h0;
         endcase
      end else begin
         // SHBE is part of the cycle width only; SA gives the offset.
         low_bits = cycle.sa; // [R2]
      end
   end

   assign addr = {cycle.la, low_bits}; // [R1] [R2]

   // ==========================================================
   // Region hits.
   function automatic logic in_win(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
      in_win = (a >= base) && (a <= base + (size - 32'h1));
   endfunction : in_win

   logic alias_4gm1_en;
   logic alias_4g_en;
   logic alias_16m_en;
   logic [LOW_REGIONS-1:0] conv_low_hit;
   logic [LOW_REGIONS-1:0] alias_4gm1_low_hit;
   logic [LOW_REGIONS-1:0] alias_4g_low_hit;
   logic [LOW_REGIONS-1:0] low_hit;

   // Each alias location has one enable shared by every region that it carries.
   assign alias_4gm1_en = bios_cs_b[CSB_ALIAS_4GM1_EN]; // [R8]
   assign alias_4g_en = bios_cs_b[CSB_ALIAS_4G_EN]; // [R8]
   assign alias_16m_en = bios_cs_b[CSB_ALIAS_16M_EN]; // [R8]

   genvar gi;
   generate
      for (gi = 0; gi < LOW_REGIONS; gi++) begin : g_low
         localparam logic [31:0] OFS = LOW_REGION_SIZE * gi;
         logic region_en;
         assign region_en = bios_cs_a[gi]; // [R6]
         assign conv_low_hit[gi] = in_win(addr, CONV_LOW_BASE + OFS, LOW_REGION_SIZE) && region_en; // [R5] [R6]
         assign alias_4gm1_low_hit[gi] = in_win(addr, ALIAS_4GM1_LOW_BASE + OFS, LOW_REGION_SIZE)
            && region_en && alias_4gm1_en; // [R7] [R8] [R15]
         assign alias_4g_low_hit[gi] = in_win(addr, ALIAS_4G_LOW_BASE + OFS, LOW_REGION_SIZE)
            && region_en && alias_4g_en; // [R7] [R8] [R15]
         assign low_hit[gi] = conv_low_hit[gi] || alias_4gm1_low_hit[gi] || alias_4g_low_hit[gi];
      end
   endgenerate

   // ==========================================================
   // High region and its aliases.
   logic high_en;
   logic conv_high_hit;
   logic alias_16m_high_hit;
   logic alias_4gm1_high_hit;
   logic alias_4g_high_hit;
   logic high_hit;

   assign high_en = bios_cs_a[CSA_HIGH_EN];

   // The 16M alias carries the high region only, so it has no low terms.
   assign conv_high_hit = in_win(addr, CONV_HIGH_BASE, HIGH_REGION_SIZE) && high_en; // [R5] [R6]
   assign alias_16m_high_hit = in_win(addr, ALIAS_16M_HIGH_BASE, HIGH_REGION_SIZE) && high_en
      && alias_16m_en; // [R7] [R15]
   assign alias_4gm1_high_hit = in_win(addr, ALIAS_4GM1_HIGH_BASE, HIGH_REGION_SIZE) && high_en
      && alias_4gm1_en; // [R7] [R8] [R15]
   assign alias_4g_high_hit = in_win(addr, ALIAS_4G_HIGH_BASE, HIGH_REGION_SIZE) && high_en
      && alias_4g_en; // [R7] [R8] [R15]
   assign high_hit = conv_high_hit || alias_16m_high_hit || alias_4gm1_high_hit || alias_4g_high_hit;

   // ==========================================================
   // VGA and enlarged windows.
   logic vga_low_hit;
   logic vga_high_hit;
   logic vga_hit;
   logic enl_hit;

   // VGA windows alias onto low regions 1 and 2 and need only their own enable.
   assign vga_low_hit = in_win(addr, VGA_LOW_BASE, LOW_REGION_SIZE) && bios_cs_b[CSB_LOW_VGA_EN]; // [R9] [R10]
   assign vga_high_hit = in_win(addr, VGA_HIGH_BASE, LOW_REGION_SIZE) && bios_cs_b[CSB_HIGH_VGA_EN]; // [R9] [R10]
   assign vga_hit = vga_low_hit || vga_high_hit;

   assign enl_hit = (addr >= ENL_BASE) && (addr <= ENL_LAST) && bios_cs_b[CSB_ENL_EN]; // [R11] [R12]

   // ==========================================================
   // Cycle qualifiers.
   logic mem_access;
   logic io_access;
   logic bios_hit;

   assign mem_access = cycle.valid && cycle.mem_cycle;
   assign io_access = cycle.valid && !cycle.mem_cycle;

   // An I/O cycle never selects BIOS, whatever address it carries.
   assign bios_hit = mem_access && ((|low_hit) || high_hit || vga_hit || enl_hit); // [R16]

   // ==========================================================
   // Space classification, registered.
   bcs_space_t next_space;

   always_comb begin
      next_space = SPACE_NONE;
      if (bios_hit) begin
         next_space = SPACE_BIOS; // [R3]
      end else if (io_access && other_hit.int_io) begin
         next_space = SPACE_INT_IO; // [R3]
      end else if (io_access && other_hit.config_sp) begin
         next_space = SPACE_CONFIG; // [R3]
      end else if (cycle.valid && other_hit.xbus) begin
         next_space = SPACE_XBUS; // [R3]
      end else if (mem_access && other_hit.apic) begin
         next_space = SPACE_APIC; // [R3]
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         space <= SPACE_NONE;
      end else begin
         space <= next_space;
      end
   end

   // ==========================================================
   // Formed address, registered.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         byte_addr <= 32'h0;
      end else begin
         byte_addr <= addr; // [R1] [R2]
      end
   end

   // ==========================================================
   // Chip select, registered.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bios_chip_select_n <= 1'b1;
      end else begin
         bios_chip_select_n <= !bios_hit; // [R4] [R16]
      end
   end

   // ==========================================================
   // Strap latch.
   bcs_strap_latch u_strap (
      .clock(clock),
      .rst_n(rst_n),
      .bios_location_strap_n(bios_location_strap_n),
      .bios_on_xbus(bios_on_xbus)
   );

   // ==========================================================
   // X-Bus transceiver control.
   logic next_xcvr_en_n;
   logic next_xcvr_dir;

   // The transceiver opens only for a BIOS on the X-Bus; a BIOS on the ISA bus leaves it shut.
   assign next_xcvr_en_n = !(bios_hit && bios_on_xbus); // [R14]
   // Direction points toward the system bus while the X-Bus BIOS is accessed.
   assign next_xcvr_dir = bios_hit && bios_on_xbus; // [R14]

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         xbus_xcvr_en_n <= 1'b1;
      end else begin
         xbus_xcvr_en_n <= next_xcvr_en_n; // [R14]
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         xbus_xcvr_dir <= 1'b0;
      end else begin
         xbus_xcvr_dir <= next_xcvr_dir; // [R14]
      end
   end

endmodule : bcs_decoder

/* include/bcs_pkg.sv */
package bcs_pkg;

   // ==========================================================
   // Region bases and sizes.
   localparam logic [31:0] VGA_LOW_BASE = 32'h000c0000;
   localparam logic [31:0] VGA_HIGH_BASE = 32'h000c4000;
   localparam logic [31:0] CONV_LOW_BASE = 32'h000e0000;
   localparam logic [31:0] CONV_HIGH_BASE = 32'h000f0000;
   localparam logic [31:0] ALIAS_16M_HIGH_BASE = 32'h00ff0000;
   localparam logic [31:0] ALIAS_4GM1_LOW_BASE = 32'hffee0000;
   localparam logic [31:0] ALIAS_4GM1_HIGH_BASE = 32'hffef0000;
   localparam logic [31:0] ENL_BASE = 32'hfff80000;
   localparam logic [31:0] ENL_LAST = 32'hfffdffff;
   localparam logic [31:0] ALIAS_4G_LOW_BASE = 32'hfffe0000;
   localparam logic [31:0] ALIAS_4G_HIGH_BASE = 32'hffff0000;
   localparam logic [31:0] LOW_REGION_SIZE = 32'h00004000;
   localparam logic [31:0] HIGH_REGION_SIZE = 32'h00010000;
   localparam int LOW_REGIONS = 4;

   // ==========================================================
   // Bit positions of the second chip select register.
   localparam int CSB_LOW_VGA_EN = 0;
   localparam int CSB_HIGH_VGA_EN = 1;
   localparam int CSB_ALIAS_4GM1_EN = 2;
   localparam int CSB_ALIAS_4G_EN = 3;
   localparam int CSB_ALIAS_16M_EN = 4;
   localparam int CSB_ENL_EN = 5;
   localparam logic [7:0] CSB_RESET = 8'h00;

   // Bit positions of the first chip select register.
   localparam int CSA_HIGH_EN = 4;
   localparam logic [7:0] CSA_RESET = 8'h00;

   // ==========================================================
   // Decoded address spaces.
   typedef enum logic [2:0] {
      SPACE_NONE, SPACE_BIOS, SPACE_INT_IO, SPACE_CONFIG, SPACE_XBUS, SPACE_APIC
   } bcs_space_t;

   typedef struct packed {
      logic valid;
      logic eisa_master;
      logic mem_cycle;
      logic [31:2] la;
      logic [3:0] be_n;
      logic [1:0] sa;
      logic shbe_n;
   } bcs_cycle_t;

   typedef struct packed {
      logic int_io;
      logic config_sp;
      logic xbus;
      logic apic;
   } bcs_other_hit_t;

endpackage : bcs_pkg

/* core/bcs_strap_latch.sv */
`timescale 1ns/1ps
module bcs_strap_latch
   import bcs_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Strap pin.
   input wire logic bios_location_strap_n,
   // Latched location, 1 for X-Bus.
   output logic bios_on_xbus
);

   logic [2:0] sync;
   logic [2:0] filled;
   logic armed;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync <= 3'h0;
      end else begin
         sync <= {sync[1:0], bios_location_strap_n};
      end
   end

   // Marks the sync stages that hold a pin sample rather than their reset value.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         filled <= 3'h0;
      end else begin
         filled <= {filled[1:0], 1'b1};
      end
   end

   // Sample once, as soon as both late stages hold the pin and agree.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         armed <= 1'b1;
         bios_on_xbus <= 1'b0;
      end else if (armed && filled[2] && (sync[2] == sync[1])) begin
         armed <= 1'b0;
         bios_on_xbus <= sync[2]; // [R13]
      end
   end

endmodule : bcs_strap_latch

/* dv/bcs_decoder_properties.sv */
`timescale 1ns/1ps
module bcs_decoder_properties
   import bcs_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Watched ports.
   input wire bcs_cycle_t cycle,
   input wire logic [7:0] bios_cs_a,
   input wire logic [7:0] bios_cs_b,
   input wire logic bios_location_strap_n,
   input wire logic bios_chip_select_n,
   input wire bcs_space_t space,
   input wire logic [31:0] byte_addr,
   input wire logic bios_on_xbus,
   input wire logic xbus_xcvr_en_n,
   input wire logic xbus_xcvr_dir
);
   // ====================
   // Checks.
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [3:0] since;
   wire mem = cycle.valid && cycle.mem_cycle;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) since <= 4'h0;
      else if (since != 4'hf) since <= since + 4'h1;
   end
   sequence s_low1;
      mem && cycle.la == CONV_LOW_BASE[31:2] && bios_cs_a[0];
   endsequence
   sequence s_bios;
      !bios_chip_select_n && space == SPACE_BIOS;
   endsequence
   a_low_hit: assert property (s_low1 |=> s_bios) else $error("low hit missed");
   a_low_off: assert property (mem && cycle.la[31:16] == 16'h000e && !bios_cs_a[cycle.la[15:14]]
      |=> bios_chip_select_n) else $error("low region not gated");
   a_alias_off: assert property (mem && cycle.la[31:20] == 12'hffe && !bios_cs_b[CSB_ALIAS_4GM1_EN]
      |=> bios_chip_select_n) else $error("alias not gated");
   a_vga_low: assert property (mem && cycle.la[31:14] == VGA_LOW_BASE[31:14] && bios_cs_b[CSB_LOW_VGA_EN]
      |=> !bios_chip_select_n) else $error("vga hit missed");
   a_enl_hit: assert property (mem && cycle.la >= ENL_BASE[31:2] && cycle.la <= ENL_LAST[31:2]
      && bios_cs_b[CSB_ENL_EN] |=> !bios_chip_select_n) else $error("enlarged hit missed");
   a_io_quiet: assert property (!mem |=> bios_chip_select_n) else $error("select on non-memory");
   a_isa_addr: assert property (cycle.valid && !cycle.eisa_master
      |=> byte_addr[1:0] == $past(cycle.sa)) else $error("isa low bits wrong");
   a_xcvr_drive: assert property (!bios_chip_select_n && bios_on_xbus && $stable(bios_on_xbus)
      |-> !xbus_xcvr_en_n && xbus_xcvr_dir) else $error("xcvr not driven");
   a_strap_hold: assert property (since == 4'hf |-> $stable(bios_on_xbus)
      && bios_on_xbus == bios_location_strap_n) else $error("strap not held");
endmodule : bcs_decoder_properties

/* dv/bcs_board.sv */
`timescale 1ns/1ps
module bcs_board (
   // Reset and chosen level.
   input wire logic rst_n,
   input wire logic want_xbus,
   // Strap pin.
   output logic bios_location_strap_n
);
   // The strap follows the chosen level only while reset is low and holds it after.
   always_latch begin
      if (!rst_n) bios_location_strap_n <= want_xbus;
   end
endmodule : bcs_board

/* dv/test_bcs_decoder.sv */
`timescale 1ns/1ps
module test_bcs_decoder
   import bcs_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   bcs_cycle_t cycle = '0;
   bcs_other_hit_t other_hit = '0;
   logic [7:0] bios_cs_a = 8'h00;
   logic [7:0] bios_cs_b = 8'h00;
   logic want_xbus = 1'b1;
   logic bios_location_strap_n, bios_chip_select_n, bios_on_xbus, xbus_xcvr_en_n, xbus_xcvr_dir;
   bcs_space_t space;
   logic [31:0] byte_addr;
   logic [31:0] base [3] = '{32'h000e0000, 32'hffee0000, 32'hfffe0000};
   int failures = 0;
   int checks = 0;
   always #2 clock = ~clock;
   bcs_board board (.rst_n, .want_xbus, .bios_location_strap_n);
   bcs_decoder dut (.clock, .rst_n, .cycle, .other_hit, .bios_cs_a, .bios_cs_b, .bios_location_strap_n,
      .bios_chip_select_n, .space, .byte_addr, .bios_on_xbus, .xbus_xcvr_en_n, .xbus_xcvr_dir);
   // ====================
   // Shared tasks.
   task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp
   task automatic access(logic [31:0] addr, logic mem, logic exp_n);
      @(negedge clock);
      cycle = '{1'b1, 1'b1, mem, addr[31:2], 4'he, 2'h0, 1'b1};
      @(negedge clock);
      cmp("select", {31'h0, exp_n}, {31'h0, bios_chip_select_n});
   endtask : access
   task automatic do_reset(logic want);
      @(negedge clock);
      rst_n = 1'b0;
      want_xbus = want;
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      repeat (6) @(negedge clock);
      cmp("location", {31'h0, want}, {31'h0, bios_on_xbus});
   endtask : do_reset
   task automatic give_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   // ====================
   // Scenarios.
   task automatic t_conv();
      logic [31:0] off;
      for (int b = 0; b < 3; b++) begin
         for (int k = 0; k < 5; k++) begin
            off = (k < 4) ? k * LOW_REGION_SIZE : CONV_HIGH_BASE - CONV_LOW_BASE;
            bios_cs_b = 8'h0c;
            bios_cs_a = 8'h01 << k;
            access(base[b] + off, 1'b1, 1'b0);
            bios_cs_a = ~(8'h01 << k) & 8'h1f;
            access(base[b] + off, 1'b1, 1'b1);
            bios_cs_a = 8'h01 << k;
            bios_cs_b = 8'h00;
            access(base[b] + off, 1'b1, b != 0);
         end
      end
   endtask : t_conv
   task automatic t_misc();
      bios_cs_a = 8'h00;
      bios_cs_b = 8'h01;
      access(VGA_LOW_BASE, 1'b1, 1'b0);
      access(VGA_HIGH_BASE, 1'b1, 1'b1);
      bios_cs_b = 8'h02;
      access(VGA_LOW_BASE + 32'h3ffc, 1'b1, 1'b1);
      access(VGA_HIGH_BASE + 32'h3ffc, 1'b1, 1'b0);
      bios_cs_b = 8'h20;
      access(ENL_BASE, 1'b1, 1'b0);
      access(ENL_LAST - 32'h3, 1'b1, 1'b0);
      access(ENL_BASE - 32'h4, 1'b1, 1'b1);
      bios_cs_b = 8'h1f;
      access(ENL_BASE, 1'b1, 1'b1);
      bios_cs_a = 8'h10;
      access(ALIAS_16M_HIGH_BASE, 1'b1, 1'b0);
      bios_cs_b = 8'h0f;
      access(ALIAS_16M_HIGH_BASE, 1'b1, 1'b1);
      bios_cs_a = 8'h1f;
      access(CONV_LOW_BASE, 1'b0, 1'b1);
      access(32'h000d0000, 1'b1, 1'b1);
   endtask : t_misc
   task automatic t_addr();
      bios_cs_a = 8'h01;
      other_hit = '{1'b1, 1'b0, 1'b0, 1'b0};
      cycle = '{1'b1, 1'b1, 1'b1, CONV_LOW_BASE[31:2], 4'hb, 2'h0, 1'b1};
      @(negedge clock);
      cmp("eisa address", CONV_LOW_BASE + 32'h2, byte_addr);
      cmp("space", {29'h0, SPACE_BIOS}, {29'h0, space});
      cycle = '{1'b1, 1'b0, 1'b0, 30'h00034000, 4'h0, 2'h3, 1'b0};
      @(negedge clock);
      cmp("isa address", 32'h000d0003, byte_addr);
      cmp("space", {29'h0, SPACE_INT_IO}, {29'h0, space});
      other_hit = '{1'b0, 1'b1, 1'b0, 1'b0};
      @(negedge clock);
      cmp("space", {29'h0, SPACE_CONFIG}, {29'h0, space});
      other_hit = '{1'b0, 1'b0, 1'b1, 1'b0};
      @(negedge clock);
      cmp("space", {29'h0, SPACE_XBUS}, {29'h0, space});
      other_hit = '{1'b0, 1'b0, 1'b0, 1'b1};
      cycle.mem_cycle = 1'b1;
      @(negedge clock);
      cmp("space", {29'h0, SPACE_APIC}, {29'h0, space});
      other_hit = '0;
   endtask : t_addr
   task automatic t_xcvr();
      for (int w = 1; w >= 0; w--) begin
         do_reset(w[0]);
         access(CONV_LOW_BASE, 1'b1, 1'b0);
         cmp("xcvr enable", {31'h0, !w[0]}, {31'h0, xbus_xcvr_en_n});
         cmp("xcvr dir", {31'h0, w[0]}, {31'h0, xbus_xcvr_dir});
      end
   endtask : t_xcvr
   initial begin
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      repeat (6) @(negedge clock);
      t_conv();
      t_misc();
      t_addr();
      t_xcvr();
      give_verdict();
   end
   initial begin
      #20000;
      failures++;
      give_verdict();
   end
endmodule : test_bcs_decoder
bind bcs_decoder bcs_decoder_properties u_props (.clock, .rst_n, .cycle, .bios_cs_a, .bios_cs_b,
   .bios_location_strap_n, .bios_chip_select_n, .space, .byte_addr, .bios_on_xbus, .xbus_xcvr_en_n, .xbus_xcvr_dir);
